// *** common/pulse_divider_pkg.sv ***
// Constants and state types shared by the encoder pulse divider files
package pulse_divider_pkg;

   // ----------------------------------------------------------------
   // Divider setting
   // ----------------------------------------------------------------
   localparam int unsigned     RATIO_W       = 15;
   localparam logic [14:0]     RATIO_MIN     = 15'h0010;   // 16
   localparam logic [14:0]     RATIO_MAX     = 15'h4000;   // 16384
   localparam logic [14:0]     RATIO_DEFAULT = 15'h4000;   // 16384

   // ----------------------------------------------------------------
   // Encoder resolution (lines per revolution, four edges per line)
   // ----------------------------------------------------------------
   localparam logic [15:0]     ENC_LINES     = 16'h4000;   // 16384

   // ----------------------------------------------------------------
   // Input bit positions inside the synchroniser vectors
   // ----------------------------------------------------------------
   localparam int unsigned     BIT_A         = 0;
   localparam int unsigned     BIT_B         = 1;
   localparam int unsigned     BIT_Z         = 2;

   // ----------------------------------------------------------------
   // Clock cycles after reset before the decoder may report a step
   // ----------------------------------------------------------------
   localparam logic [1:0]      SETTLE_EDGES  = 2'h3;

   // ----------------------------------------------------------------
   // Divider modes
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      MODE_LOAD = 1'b0,
      MODE_RUN  = 1'b1
   } mode_type;

   // Divider state
   typedef struct packed {
      mode_type    mode;
      logic [14:0] ratio;
      logic [14:0] acc;
      logic [1:0]  phase;
      logic        out_a;
      logic        out_b;
      logic        out_c;
   } div_state_type;

   localparam div_state_type DIV_RESET = '{
      mode:  MODE_LOAD,
      ratio: RATIO_DEFAULT,
      acc:   15'h0000,
      phase: 2'h0,
      out_a: 1'b0,
      out_b: 1'b0,
      out_c: 1'b0
   };

   // Encoder input decoder state
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] stable;
      logic       step;
      logic       up;
      logic [1:0] settle;
   } dec_state_type;

   localparam dec_state_type DEC_RESET = '{
      s1:     3'h0,
      s2:     3'h0,
      s3:     3'h0,
      stable: 3'h0,
      step:   1'b0,
      up:     1'b0,
      settle: 2'h0
   };

endpackage : pulse_divider_pkg

// *** design/encoder_input_decoder.sv ***
// Encoder pin synchroniser and quadrature edge decoder
`timescale 1ns/1ns
module encoder_input_decoder
   import pulse_divider_pkg::*;
(
   input  wire logic sys_clk,      // System clock, 50 MHz
   input  wire logic nrst,         // Synchronous reset, active low
   input  wire logic enc_a,        // Encoder phase A pin
   input  wire logic enc_b,        // Encoder phase B pin
   input  wire logic enc_z,        // Encoder index pin
   output logic      enc_step,     // One-cycle pulse per quadrature edge
   output logic      enc_up,       // Direction of that edge, high = forward
   output logic      enc_index     // Filtered index level
);

   dec_state_type cur;
   dec_state_type next_cur;
   logic [1:0]    old_pos;
   logic [1:0]    new_pos;
   logic [1:0]    delta;

   // ----------------------------------------------------------------
   // Three-stage sync, accept a level once stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      next_cur    = cur;
      next_cur.s1 = {enc_z, enc_b, enc_a};
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;
      next_cur.stable = (cur.s2 & cur.s3) | (cur.stable & (cur.s2 ^ cur.s3));
      // Gray position of old and new accepted A/B levels
      old_pos = {cur.stable[BIT_A], cur.stable[BIT_A] ^ cur.stable[BIT_B]};
      new_pos = {next_cur.stable[BIT_A],
                 next_cur.stable[BIT_A] ^ next_cur.stable[BIT_B]};
      delta   = new_pos - old_pos;
      // A double jump carries no direction and is dropped
      next_cur.step = (delta == 2'h1) || (delta == 2'h3);
      next_cur.up   = (delta == 2'h1);
      // Right after reset the sync stages still hold reset zeros; take the
      // pin level as it arrives and report no step, so a shaft parked at a
      // nonzero position is not read as one false edge
      if (cur.settle != SETTLE_EDGES) begin
         next_cur.settle = cur.settle + 2'h1;
         next_cur.stable = cur.s2;
         next_cur.step   = 1'b0;
         next_cur.up     = 1'b0;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cur <= DEC_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   assign enc_step  = cur.step;
   assign enc_up    = cur.up;
   assign enc_index = cur.stable[BIT_Z];

endmodule : encoder_input_decoder

// *** design/encoder_pulse_divider_output.sv ***
// Encoder pulse divider: emulated A/B quadrature and index output
`timescale 1ns/1ns
module encoder_pulse_divider_output
   import pulse_divider_pkg::*;
(
   input  wire logic        sys_clk,                  // System clock
   input  wire logic        nrst,                     // Sync reset, low
   input  wire logic        enc_a,                    // Encoder A pin
   input  wire logic        enc_b,                    // Encoder B pin
   input  wire logic        enc_z,                    // Encoder index pin
   input  wire logic [14:0] divider_ratio_setting,    // Pulses per rev
   input  wire logic        direction_reverse_select, // Reversal option
   output logic             divided_phase_a_out,      // Divided phase A
   output logic             divided_phase_b_out,      // Divided phase B
   output logic             index_phase_c_out         // Index phase C
);

   // Divider state and the decoder's per-edge handshake
   div_state_type cur;
   div_state_type next_cur;
   logic          enc_step;
   logic          enc_up;
   logic          enc_index;
   logic [15:0]   sum;

   // ----------------------------------------------------------------
   // Encoder input
   // ----------------------------------------------------------------
   encoder_input_decoder u_decoder (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .enc_a     (enc_a),
      .enc_b     (enc_b),
      .enc_z     (enc_z),
      .enc_step  (enc_step),
      .enc_up    (enc_up),
      .enc_index (enc_index)
   );

   // Limit a setting to the accepted range. Out-of-range values are
   // clamped rather than refused, so a bad setting still gives a usable
   // pulse rate instead of a silent output
   function automatic logic [14:0] clamp_ratio(input logic [14:0] value);
      if (value < RATIO_MIN) begin
         return RATIO_MIN;
      end else if (value > RATIO_MAX) begin
         return RATIO_MAX;
      end
      return value;
   endfunction : clamp_ratio

   // ----------------------------------------------------------------
   // Rate divider and output phase stepper
   // ----------------------------------------------------------------
   // The accumulator gains the ratio on every forward encoder edge and
   // loses it on every reverse edge; each wrap through the encoder
   // line count is one output edge, so a revolution of 4*lines edges
   // yields 4*ratio output edges. Reverse steps undo forward steps
   // exactly, so jitter on an edge never accumulates drift.
   always_comb begin
      next_cur = cur;
      // One bit wider than the accumulator so the wrap test sees the carry
      sum      = {1'b0, cur.acc} + {1'b0, cur.ratio};
      case (cur.mode)
         MODE_LOAD: begin
            // Setting sampled once after release of reset only
            next_cur.ratio = clamp_ratio(divider_ratio_setting);
            next_cur.mode  = MODE_RUN;
         end
         MODE_RUN: begin
            // Forward edges add the ratio, reverse edges take it back
            if (enc_step) begin
               if (enc_up) begin
                  if (sum >= ENC_LINES) begin
                     next_cur.acc   = 15'(sum - ENC_LINES);
                     next_cur.phase = cur.phase + 2'h1;
                  end else begin
                     next_cur.acc = sum[14:0];
                  end
               end else begin
                  // A borrow through the line count steps the phase back
                  if (cur.acc < cur.ratio) begin
                     next_cur.acc   = 15'(({1'b0, cur.acc} + ENC_LINES)
                                          - {1'b0, cur.ratio});
                     next_cur.phase = cur.phase - 2'h1;
                  end else begin
                     next_cur.acc = cur.acc - cur.ratio;
                  end
               end
            end
         end
         default: begin
            next_cur.mode = MODE_LOAD;
         end
      endcase
      // Gray phase to A/B: one pin changes per step, B a quarter off A
      next_cur.out_a = next_cur.phase[1];
      next_cur.out_b = next_cur.phase[1] ^ next_cur.phase[0];
      // Forward edges walk the phase up, so B leads A going forward and
      // A leads B in reverse; the reversal option is not read here
      // Waveform is built from encoder direction alone
      next_cur.out_c = enc_index;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cur <= DIV_RESET;
      end else begin
         cur <= next_cur;
      end
   end

   // Pins come straight from the state register, no logic after the flop
   assign divided_phase_a_out = cur.out_a;
   assign divided_phase_b_out = cur.out_b;
   assign index_phase_c_out   = cur.out_c;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // All checks run on the system clock and sleep through reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   chk_quad_one_edge: assert property (
      !($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
      else $error("A and B changed together");

   chk_index_follow: assert property (
      ##1 index_phase_c_out == $past(enc_index))
      else $error("Index output does not follow encoder index");

   chk_full_ratio: assert property (
      cur.mode == MODE_RUN && cur.ratio == RATIO_MAX && enc_step
      |=> ($changed(divided_phase_a_out) || $changed(divided_phase_b_out)))
      else $error("Full ratio missed an output edge");

   chk_no_cause: assert property (
      cur.mode == MODE_RUN && !enc_step
      |=> $stable(divided_phase_a_out) && $stable(divided_phase_b_out))
      else $error("Output edge without encoder edge");

   chk_ratio_range: assert property (
      cur.mode == MODE_RUN
      |-> cur.ratio >= RATIO_MIN && cur.ratio <= RATIO_MAX)
      else $error("Ratio outside accepted range");

   chk_ratio_hold: assert property (
      cur.mode == MODE_RUN |=> $stable(cur.ratio) && cur.mode == MODE_RUN)
      else $error("Ratio changed without restart");

   chk_reverse_ignored: assert property (
      $changed(direction_reverse_select) && !enc_step
      |=> $stable(divided_phase_a_out) && $stable(divided_phase_b_out))
      else $error("Reversal option altered the output");

   chk_direction_sense: assert property (
      $changed(cur.phase)
      |-> cur.phase == ($past(enc_up) ? $past(cur.phase) + 2'h1
                                      : $past(cur.phase) - 2'h1))
      else $error("Output phase moved against encoder direction");

   // Divider arithmetic, setting capture and index path
   chk_acc_bound: assert property (
      {1'b0, cur.acc} < ENC_LINES)
      else $error("Accumulator reached the line count");

   chk_reset_state: assert property (
      !$past(nrst)
      |-> cur.mode == MODE_LOAD && cur.ratio == RATIO_DEFAULT
          && !divided_phase_a_out && !divided_phase_b_out
          && !index_phase_c_out)
      else $error("State after reset is not the default");

   chk_ratio_latch: assert property (
      cur.mode == MODE_LOAD && divider_ratio_setting >= RATIO_MIN
      && divider_ratio_setting <= RATIO_MAX
      |=> cur.ratio == $past(divider_ratio_setting))
      else $error("In-range setting not taken at restart");

   chk_clamp_low: assert property (
      cur.mode == MODE_LOAD && divider_ratio_setting < RATIO_MIN
      |=> cur.ratio == RATIO_MIN)
      else $error("Low setting not clamped to the minimum");

   chk_clamp_high: assert property (
      cur.mode == MODE_LOAD && divider_ratio_setting > RATIO_MAX
      |=> cur.ratio == RATIO_MAX)
      else $error("High setting not clamped to the maximum");

   chk_load_no_step: assert property (
      cur.mode == MODE_LOAD |=> $stable(cur.phase))
      else $error("Output stepped while the setting was loading");

   chk_index_undivided: assert property (
      $changed(enc_index) |=> $changed(index_phase_c_out))
      else $error("Index change did not reach the output");

   // Main scenarios reached
   cov_forward_edge: cover property (
      enc_step && enc_up ##1 $changed(cur.phase));
   cov_reverse_edge: cover property (
      enc_step && !enc_up ##1 $changed(cur.phase));
   cov_index_pulse: cover property (
      $rose(index_phase_c_out) ##[1:1000] $fell(index_phase_c_out));
   cov_low_ratio_wrap: cover property (
      cur.ratio == RATIO_MIN && enc_step ##1 $changed(cur.phase));
   cov_clamped_load: cover property (
      cur.mode == MODE_LOAD && divider_ratio_setting > RATIO_MAX);

endmodule : encoder_pulse_divider_output

// *** bench/quad_host_counter.sv ***
// Host controller model counting the divided quadrature feedback
`timescale 1ns/1ns
module quad_host_counter (
   input  wire logic   sys_clk,   // System clock
   input  wire logic   nrst,      // Sync reset, low
   input  wire logic   phase_a,   // Divided phase A
   input  wire logic   phase_b,   // Divided phase B
   output logic [31:0] count,     // Net edges, forward positive
   output logic        jump_seen  // Both phases moved at once
);
   logic [1:0] pos;
   logic [1:0] last;

   // Gray position of the A/B pair
   assign pos = {phase_a, phase_a ^ phase_b};

   // Quarter-step decode; only a one-step move is a legal edge
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         count <= 32'h0;
         jump_seen <= 1'b0;
         last <= 2'h0;
      end else begin
         last <= pos;
         if (pos - last == 2'h1) begin
            count <= count + 32'h1;
         end else if (pos - last == 2'h3) begin
            count <= count - 32'h1;
         end else if (pos - last == 2'h2) begin
            jump_seen <= 1'b1;
         end
      end
   end
endmodule : quad_host_counter

// *** bench/testbench.sv ***
// Self-checking bench for the encoder pulse divider
`timescale 1ns/1ns
module testbench;
   import pulse_divider_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        enc_a = 1'b0;
   logic        enc_b = 1'b0;
   logic        enc_z = 1'b0;
   logic [14:0] setting = RATIO_MAX;
   logic        rev = 1'b0;
   logic        out_a, out_b, out_c, jump;
   logic [31:0] count;
   logic [1:0]  gpos = 2'h0;
   int          n_mismatch = 0;
   int          checks_done = 0;

   encoder_pulse_divider_output dut (.sys_clk(sys_clk), .nrst(nrst),
      .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
      .divider_ratio_setting(setting), .direction_reverse_select(rev),
      .divided_phase_a_out(out_a), .divided_phase_b_out(out_b),
      .index_phase_c_out(out_c));
   quad_host_counter host (.sys_clk(sys_clk), .nrst(nrst),
      .phase_a(out_a), .phase_b(out_b), .count(count), .jump_seen(jump));

   // 50 MHz clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // Restart with a new setting, encoder parked at position zero
   task automatic restart(logic [14:0] s);
      @(negedge sys_clk);
      nrst = 1'b0;
      setting = s;
      gpos = 2'h0;
      enc_a = 1'b0;
      enc_b = 1'b0;
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (2) @(negedge sys_clk);
   endtask : restart

   // One gray step per move, each level held four cycles
   task automatic move(int n, bit fwd);
      repeat (n) begin
         @(negedge sys_clk);
         gpos = fwd ? gpos + 2'h1 : gpos - 2'h1;
         enc_a = gpos[1];
         enc_b = gpos[1] ^ gpos[0];
         repeat (3) @(negedge sys_clk);
      end
      repeat (8) @(negedge sys_clk);
   endtask : move

   // Ratio 16384: every encoder edge gives one output edge
   task automatic sc_full_ratio();
      restart(RATIO_MAX);
      move(6, 1'b1);
      check("fwd count", count, 32'h6);
      move(9, 1'b0);
      check("rev count", count, -32'sd3);
      check("phase jump", {31'h0, jump}, 32'h0);
   endtask : sc_full_ratio

   // Ratio 16: one output edge per 1024 encoder edges
   task automatic sc_low_ratio();
      restart(RATIO_MIN);
      setting = RATIO_MAX;
      rev = 1'b1;
      move(1023, 1'b1);
      check("below wrap", count, 32'h0);
      move(1, 1'b1);
      check("at wrap", count, 32'h1);
      move(1024, 1'b1);
      check("second wrap", count, 32'h2);
      move(1, 1'b0);
      check("back one", count, 32'h1);
      check("phase jump", {31'h0, jump}, 32'h0);
   endtask : sc_low_ratio

   // High setting runs as 16384; a double step is dropped, not counted
   task automatic sc_clamp_high();
      restart(15'h7fff);
      move(2, 1'b1);
      check("high clamp", count, 32'h2);
      @(negedge sys_clk);
      gpos = gpos + 2'h2;
      enc_a = gpos[1];
      enc_b = gpos[1] ^ gpos[0];
      repeat (12) @(negedge sys_clk);
      check("jump dropped", count, 32'h2);
      move(1, 1'b1);
      check("after jump", count, 32'h3);
      check("phase jump", {31'h0, jump}, 32'h0);
   endtask : sc_clamp_high

   // Setting below 16 runs as 16: one output edge per 1024 edges
   task automatic sc_clamp_low();
      restart(15'h0008);
      move(1024, 1'b1);
      check("low clamp", count, 32'h1);
   endtask : sc_clamp_low

   // Index passes straight through while A/B stay divided
   task automatic sc_index(logic z);
      int k;
      @(negedge sys_clk);
      enc_z = z;
      k = 0;
      while (out_c !== z && k < 12) begin
         @(negedge sys_clk);
         k++;
      end
      if (k >= 12) begin
         n_mismatch++;
         give_verdict();
      end
      check("index out", {31'h0, out_c}, {31'h0, z});
      check("index latency", k, 5);
      check("no ab edge", count, 32'h1);
   endtask : sc_index

   // Main sequence
   initial begin
      repeat (3) @(negedge sys_clk);
      nrst = 1'b1;
      sc_full_ratio();
      sc_low_ratio();
      sc_clamp_high();
      sc_clamp_low();
      sc_index(1'b1);
      sc_index(1'b0);
      give_verdict();
   end
endmodule : testbench
